// >>> bench/chp_usb_port.sv
// Behavioural USB port model answering the data-line detection probes
`timescale 1ns/1ps
module chp_usb_port (
  input wire logic core_clk_i,
  input wire logic [1:0] kind_i,
  input wire logic [7:0] contact_cyc_i,
  input wire logic dp_current_src_en_i,
  input wire logic dm_pulldown_en_i,
  input wire logic dp_voltage_src_en_i,
  input wire logic dm_current_sink_en_i,
  output logic dp_high_o,
  output logic dm_high_o
);
  // Kind 0 leaves the data lines floating, 1 is a host port, 2 a charging port
  logic [7:0] cnt = 8'h00;
  logic toggle = 1'b0;
  always_ff @(posedge core_clk_i)
  begin
    toggle <= ~toggle;
    cnt <= dp_current_src_en_i ? cnt + {7'h00, cnt != 8'hFF} : 8'h00;
  end
  // Contact pulls D+ low after a settable delay; floating lines never do
  // Undriven lines toggle so a stale sample can never pass for a real answer
  always_comb
  begin
    if (dp_current_src_en_i)
      dp_high_o = (kind_i == 2'h0) || (cnt < contact_cyc_i);
    else if (dp_voltage_src_en_i)
      dp_high_o = 1'b1;
    else
      dp_high_o = toggle;
  end
  // Charging port shorts D+ onto D-, a host port leaves D- low
  always_comb
  begin
    if (dp_voltage_src_en_i && dm_current_sink_en_i)
      dm_high_o = (kind_i == 2'h2);
    else if (dm_pulldown_en_i)
      dm_high_o = 1'b0;
    else
      dm_high_o = ~toggle;
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the power-up and input detection sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import chp_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_d = 1'b0;
  logic vbus_ok = 1'b0, bat_ok = 1'b1, depl = 1'b1, sleep_ok = 1'b1, ovp = 1'b1, holds = 1'b0;
  logic ce = 1'b1, boost = 1'b0;
  logic overload = 1'b0, bat_good = 1'b0, sys_ok = 1'b0, otg = 1'b0, dp_high, dm_high;
  logic [2:0] ext_lim = 3'h7;
  logic [1:0] kind = 2'h2;
  logic [7:0] contact = 8'h02, e_rd, reg_rdata_o;
  logic [31:0] lfsr = 32'h3374;
  logic [7:0] exp_q[$];
  logic sw_on, bias_en, load_en, pg_pin, pg_oe_n, int_o, dp_src, dm_pd, dp_vsrc, dm_sink;
  logic [2:0] input_limit_o;
  int miscompares = 0, checked = 0, wcnt, i;
  logic [1:0] tk[3] = '{2'h2, 2'h1, 2'h0};
  logic [2:0] tl[3] = '{3'h5, 3'h2, 3'h0};
  // Short counts keep the run small; expectations below follow these values
  chp_powerup_seq #(.BIAS_DELAY_CYC(50), .RETRY_CYC(100), .DCD_SRC_CYC(20), .DCD_WAIT_CYC(60),
    .PRIMARY_CYC(20), .QUAL_SETTLE_CYC(4)) DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .vbus_above_uvlo_i(vbus_ok), .bat_above_uvlo_i(bat_ok),
    .bat_above_depletion_i(depl), .vbus_above_sleep_i(sleep_ok), .boost_mode_i(boost),
    .input_overvoltage_i(ovp), .source_holds_load_i(holds), .sys_overload_i(overload),
    .bat_above_good_i(bat_good), .sys_above_soft_start_i(sys_ok), .dp_high_i(dp_high), .dm_high_i(dm_high),
    .port_select_i(1'b0), .otg_i(otg), .external_limit_pin_i(ext_lim), .battery_switch_on_o(sw_on),
    .bias_regulator_en_o(bias_en), .test_load_en_o(load_en), .power_good_pin_o(pg_pin),
    .power_good_pin_oe_n_o(pg_oe_n), .int_o(int_o), .dp_current_src_en_o(dp_src), .dm_pulldown_en_o(dm_pd),
    .dp_voltage_src_en_o(dp_vsrc), .dm_current_sink_en_o(dm_sink), .input_limit_o(input_limit_o));
  chp_usb_port port (.core_clk_i(core_clk_i), .kind_i(kind), .contact_cyc_i(contact),
    .dp_current_src_en_i(dp_src), .dm_pulldown_en_i(dm_pd), .dp_voltage_src_en_i(dp_vsrc),
    .dm_current_sink_en_i(dm_sink), .dp_high_o(dp_high), .dm_high_o(dm_high));
  always #2 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Strobe for one cycle, then one idle edge so it is never reassigned in one step
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    tick(1);
    reg_wr_i <= 1'b0;
    tick(1);
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back(e);
    tick(1);
    reg_rd_i <= 1'b0;
    tick(1);
  endtask
  task automatic end_sim();
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk_i)
  begin
    rd_d <= reg_rd_i;
    if (rd_d)
    begin
      e_rd = exp_q.pop_front();
      `CHK("reg_rdata_o", e_rd, reg_rdata_o)
    end
  end
  initial
  begin
    #(4 * 20000);
    miscompares++;
    end_sim();
  end
  initial
  begin
    tick(6);
    reset_i <= 1'b0;
    tick(12);
    `CHK("switch", 1'b1, sw_on)
    `CHK("bias", 1'b0, bias_en)
    reg_read(ADDR_INPUT_CTRL, 8'h02);
    reg_read(ADDR_SYS_CTRL, 8'h01);
    reg_read(ADDR_MODE, 8'h00);
    reg_read(4'hC, 8'h00);
    reg_write(ADDR_SYS_CTRL, 8'h21);
    `CHK("switch", 1'b0, sw_on)
    reg_write(ADDR_SYS_CTRL, 8'h01);
    `CHK("switch", 1'b1, sw_on)
    // Clock enable low drops the strobe, so the disable must not land
    ce <= 1'b0;
    reg_write(ADDR_SYS_CTRL, 8'h21);
    ce <= 1'b1;
    `CHK("switch", 1'b1, sw_on)
    depl <= 1'b0;
    tick(8);
    `CHK("switch", 1'b0, sw_on)
    depl <= 1'b1;
    tick(8);
    `CHK("switch", 1'b1, sw_on)
    overload <= 1'b1;
    tick(8);
    `CHK("switch", 1'b0, sw_on)
    overload <= 1'b0;
    tick(8);
    `CHK("switch", 1'b0, sw_on)
    reg_write(ADDR_SYS_CTRL, 8'h20);
    reg_read(ADDR_SYS_CTRL, 8'h20);
    vbus_ok <= 1'b1;
    tick(10);
    `CHK("switch", 1'b1, sw_on)
    reg_read(ADDR_SYS_CTRL, 8'h00);
    tick(30);
    `CHK("bias", 1'b0, bias_en)
    wcnt = 0;
    while (bias_en !== 1'b1 && wcnt < 30) begin tick(1); wcnt++; end
    `CHK("bias", 1'b1, bias_en)
    `CHK("load", 1'b1, load_en)
    tick(40);
    `CHK("pg_oe_n", 1'b1, pg_oe_n)
    ovp <= 1'b0;
    holds <= 1'b1;
    tick(40);
    `CHK("pg_oe_n", 1'b1, pg_oe_n)
    wcnt = 0;
    while (int_o !== 1'b1 && wcnt < 60) begin tick(1); wcnt++; end
    `CHK("int", 1'b1, int_o)
    tick(2);
    `CHK("pg_oe_n", 1'b0, pg_oe_n)
    `CHK("pg_pin", 1'b0, pg_pin)
    tick(130);
    reg_read(ADDR_STATUS, 8'h85);
    reg_read(ADDR_INPUT_CTRL, 8'h05);
    `CHK("limit", 3'h0, input_limit_o)
    sys_ok <= 1'b1;
    tick(8);
    `CHK("limit", 3'h5, input_limit_o)
    reg_write(ADDR_INPUT_CTRL, 8'h07);
    tick(2);
    `CHK("limit", 3'h7, input_limit_o)
    reg_write(ADDR_INPUT_CTRL, 8'h05);
    for (i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      ext_lim <= lfsr[2:0];
      tick(8);
      `CHK("limit", (lfsr[2:0] < 3'h5) ? lfsr[2:0] : 3'h5, input_limit_o)
    end
    ext_lim <= 3'h7;
    // Slow contact on the host case exercises the long wait for D+ to fall
    for (i = 0; i < 3; i++)
    begin
      kind <= tk[i];
      otg <= (i == 1);
      contact <= (i == 1) ? 8'd40 : 8'd2;
      reg_write(ADDR_SYS_CTRL, 8'h81);
      tick(130);
      reg_read(ADDR_SYS_CTRL, 8'h01);
      reg_read(ADDR_STATUS, {tk[i], 6'h05});
      reg_read(ADDR_INPUT_CTRL, {5'h00, tl[i]});
    end
    bat_good <= 1'b1;
    kind <= 2'h1;
    otg <= 1'b0;
    reg_write(ADDR_SYS_CTRL, 8'h81);
    tick(130);
    reg_read(ADDR_INPUT_CTRL, 8'h80);
    `CHK("bias", 1'b0, bias_en)
    vbus_ok <= 1'b0;
    tick(10);
    reg_read(ADDR_INPUT_CTRL, 8'h00);
    reg_write(ADDR_MODE, 8'h01);
    vbus_ok <= 1'b1;
    tick(250);
    reg_read(ADDR_INPUT_CTRL, 8'h80);
    vbus_ok <= 1'b0;
    tick(10);
    reg_read(ADDR_INPUT_CTRL, 8'h80);
    vbus_ok <= 1'b1;
    tick(100);
    `CHK("bias", 1'b0, bias_en)
    reg_write(ADDR_INPUT_CTRL, 8'h00);
    reg_read(ADDR_INPUT_CTRL, 8'h00);
    sleep_ok <= 1'b0;
    tick(120);
    `CHK("bias", 1'b0, bias_en)
    // Boost mode inverts the sleep sense, so input below sleep enables bias
    boost <= 1'b1;
    tick(70);
    `CHK("bias", 1'b1, bias_en)
    tick(5);
    end_sim();
  end
endmodule

// >>> include/chp_pkg.sv
// Constants for the charger power-up and input detection sequencer
package chp_pkg;
  // Clock rate and derived cycle counts
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BIAS_DELAY_MS = 220;
  localparam int unsigned RETRY_MS = 2000;
  localparam int unsigned DCD_SRC_MS = 40;
  localparam int unsigned DCD_WAIT_MS = 500;
  localparam int unsigned PRIMARY_MS = 40;
  localparam int unsigned QUAL_SETTLE_US = 10;
  localparam int unsigned BIAS_DELAY_CYC = BIAS_DELAY_MS * CYC_PER_MS;
  localparam int unsigned RETRY_CYC = RETRY_MS * CYC_PER_MS;
  localparam int unsigned DCD_SRC_CYC = DCD_SRC_MS * CYC_PER_MS;
  localparam int unsigned DCD_WAIT_CYC = DCD_WAIT_MS * CYC_PER_MS;
  localparam int unsigned PRIMARY_CYC = PRIMARY_MS * CYC_PER_MS;
  localparam int unsigned QUAL_SETTLE_CYC = QUAL_SETTLE_US * (CLK_HZ / 1000000);
  // Register offsets
  localparam logic [3:0] ADDR_INPUT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_MODE = 4'h3;
  // Field positions
  localparam int HIZ_BIT = 7;
  localparam int FORCE_DET_BIT = 7;
  localparam int BSW_DIS_BIT = 5;
  localparam int WDOG_LSB = 0;
  localparam int PG_STAT_BIT = 2;
  localparam int SRC_TYPE_LSB = 6;
  localparam int HIZ_STAT_BIT = 1;
  localparam int BSW_STAT_BIT = 0;
  localparam int HOST_MODE_BIT = 0;
  // Input limit codes
  localparam logic [2:0] LIM_100MA = 3'h0;
  localparam logic [2:0] LIM_500MA = 3'h2;
  localparam logic [2:0] LIM_1500MA = 3'h5;
  localparam logic [2:0] LIM_3000MA = 3'h7;
  // Source type codes
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_HOST = 2'h1;
  localparam logic [1:0] SRC_CHARGER = 2'h2;
  // Values after reset, and the watchdog off code
  localparam logic [2:0] LIMIT_RST = 3'h2;
  localparam logic [1:0] WDOG_RST = 2'h1;
  localparam logic [1:0] WDOG_OFF = 2'h0;
  localparam logic HOST_MODE_RST = 1'b0;
  typedef enum logic [3:0] {
    ST_IDLE, ST_BIAS_DELAY, ST_QUALIFY, ST_RETRY, ST_DET_BEGIN,
    ST_DCD_SRC, ST_DCD_WAIT, ST_PRIMARY, ST_READY, ST_HIZ_HOLD
  } chp_state_t;
endpackage

// >>> verilog/chp_powerup_seq.sv
// Power-up, input qualification and input current limit detection sequencer
// Notes on behaviour
// - Supply rise resets all registers, bus ready
// - Battery only above depletion: switch closed
// - Overload on battery opens switch until attach
// - Disable bit forces battery switch open
// - Bias on: input ok, sleep ok, delay
// - Any bias condition fails: bias off
// - Qualify: below 18 V, above 3.8 V loaded
// - Pass sets status, pin low, interrupt
// - Failed source test retried every 2 s
// - Detect each attach unless host-mode high-impedance
// - Host-written limit field is applied
// - Contact detection needs supply and power good
// - Contact detect 40 ms, wait 0.5 s
// - Primary detect 40 ms, classify D- level
// - Data-line results set limit and type
// - Select pins set limit on pin variants
// - 100 mA host, good battery: high-impedance
// - Host mode: hold until host clears bit
// - Default mode: clear bit on removal
// - Force bit starts detection, self-clears
// - Soft-start 100 mA below 2.2 V
`timescale 1ns/1ps
module chp_powerup_seq #(
  parameter bit DATA_LINE_DETECT = 1'b1,
  parameter bit HIGH_LIMIT_VARIANT = 1'b0,
  parameter int unsigned BIAS_DELAY_CYC = chp_pkg::BIAS_DELAY_CYC,
  parameter int unsigned RETRY_CYC = chp_pkg::RETRY_CYC,
  parameter int unsigned DCD_SRC_CYC = chp_pkg::DCD_SRC_CYC,
  parameter int unsigned DCD_WAIT_CYC = chp_pkg::DCD_WAIT_CYC,
  parameter int unsigned PRIMARY_CYC = chp_pkg::PRIMARY_CYC,
  parameter int unsigned QUAL_SETTLE_CYC = chp_pkg::QUAL_SETTLE_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic vbus_above_uvlo_i,
  input wire logic bat_above_uvlo_i,
  input wire logic bat_above_depletion_i,
  input wire logic vbus_above_sleep_i,
  input wire logic boost_mode_i,
  input wire logic input_overvoltage_i,
  input wire logic source_holds_load_i,
  input wire logic sys_overload_i,
  input wire logic bat_above_good_i,
  input wire logic sys_above_soft_start_i,
  input wire logic dp_high_i,
  input wire logic dm_high_i,
  input wire logic port_select_i,
  input wire logic otg_i,
  input wire logic [2:0] external_limit_pin_i,
  output logic battery_switch_on_o,
  output logic bias_regulator_en_o,
  output logic test_load_en_o,
  output logic power_good_pin_o,
  output logic power_good_pin_oe_n_o,
  output logic int_o,
  output logic dp_current_src_en_o,
  output logic dm_pulldown_en_o,
  output logic dp_voltage_src_en_o,
  output logic dm_current_sink_en_o,
  output logic [2:0] input_limit_o
);
  import chp_pkg::*;

  localparam int NSYNC = 17;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;
  logic [NSYNC-1:0] pin_f;
  logic vbus_s, bat_s, depl_s, sleep_s, boost_s, ovp_s, src_ok_s, ovl_s;
  logic batgd_s, sys_ok_s, dp_s, dm_s, psel_s, otg_s;
  logic [2:0] ext_lim_s;
  logic supply_prev, soft_rst, vbus_prev, vbus_attach;
  chp_state_t state;
  logic [31:0] tmr;
  logic hiz_bit, force_det, bsw_dis, host_mode, pg_status, ship_mode, ovl_latch;
  logic [2:0] limit_field;
  logic [1:0] wdog_field, src_type;
  logic bias_cond, det_done, go_hiz;
  logic [2:0] det_lim;
  logic [1:0] det_type;
  logic wr_input, wr_sys;

  assign pin_raw = {external_limit_pin_i, otg_i, port_select_i, dm_high_i, dp_high_i,
                    sys_above_soft_start_i, bat_above_good_i, sys_overload_i, source_holds_load_i,
                    input_overvoltage_i, boost_mode_i, vbus_above_sleep_i, bat_above_depletion_i,
                    bat_above_uvlo_i, vbus_above_uvlo_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge core_clk_i)
      begin
        if (reset_i)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
          pin_f[gi] <= 1'b0;
        end
        else if (ce_i)
        begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
          if (sync_b[gi] == sync_c[gi])
            pin_f[gi] <= sync_c[gi];
        end
      end
    end
  endgenerate

  assign {ext_lim_s, otg_s, psel_s, dm_s, dp_s, sys_ok_s, batgd_s, ovl_s, src_ok_s,
          ovp_s, boost_s, sleep_s, depl_s, bat_s, vbus_s} = pin_f;

  // Either supply rising from none acts as a power-on reset
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      supply_prev <= 1'b0;
      vbus_prev <= 1'b0;
    end
    else if (ce_i)
    begin
      supply_prev <= vbus_s | bat_s;
      vbus_prev <= vbus_s;
    end
  end

  assign soft_rst = reset_i | (ce_i & ~supply_prev & (vbus_s | bat_s));
  assign vbus_attach = vbus_s & ~vbus_prev;
  assign wr_input = reg_wr_i && reg_addr_i == ADDR_INPUT_CTRL;
  assign wr_sys = reg_wr_i && reg_addr_i == ADDR_SYS_CTRL;

  // Sleep comparator sense flips in boost mode
  assign bias_cond = vbus_s && (boost_s ? ~sleep_s : sleep_s);

  function automatic logic [2:0] host_limit(input logic otg);
    host_limit = otg ? LIM_500MA : LIM_100MA;
  endfunction

  // Detection results, valid in the cycle det_done is high
  always_comb
  begin
    det_done = 1'b0;
    det_lim = LIM_100MA;
    det_type = SRC_NONE;
    unique case (state)
      ST_DET_BEGIN:
      begin
        if (pg_status && !DATA_LINE_DETECT)
        begin
          det_done = 1'b1;
          det_lim = psel_s ? host_limit(otg_s) : (HIGH_LIMIT_VARIANT ? LIM_3000MA : LIM_1500MA);
          det_type = psel_s ? SRC_HOST : SRC_CHARGER;
        end
      end
      ST_DCD_WAIT:
      begin
        // Contact timeout gives 100 mA, floating lines
        if (dp_s && tmr >= DCD_WAIT_CYC - 1)
          det_done = 1'b1;
      end
      ST_PRIMARY:
      begin
        // D- low is a host port, high a charger
        if (tmr >= PRIMARY_CYC - 1)
        begin
          det_done = 1'b1;
          det_lim = dm_s ? LIM_1500MA : host_limit(otg_s);
          det_type = dm_s ? SRC_CHARGER : SRC_HOST;
        end
      end
      default:
      begin
        det_done = 1'b0;
      end
    endcase
  end

  // Weak host port with good battery parks the input
  assign go_hiz = det_done && det_type == SRC_HOST && det_lim == LIM_100MA && batgd_s;

  // Sequencer and its shared timer
  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
    begin
      state <= ST_IDLE;
      tmr <= 32'h0;
    end
    else if (ce_i)
    begin
      if (!vbus_s)
      begin
        state <= ST_IDLE;
        tmr <= 32'h0;
      end
      else
      begin
        tmr <= tmr + 32'h1;
        unique case (state)
          ST_IDLE:
          begin
            state <= ST_BIAS_DELAY;
            tmr <= 32'h0;
          end
          ST_BIAS_DELAY:
          begin
            // Host-mode parked input skips detection on attach
            if (hiz_bit)
              state <= ST_HIZ_HOLD;
            // Delay restarts whenever a condition drops
            else if (!bias_cond)
              tmr <= 32'h0;
            else if (tmr >= BIAS_DELAY_CYC - 1)
            begin
              state <= ST_QUALIFY;
              tmr <= 32'h0;
            end
          end
          ST_QUALIFY:
          begin
            // Judge the source after the test load settles
            if (tmr >= QUAL_SETTLE_CYC - 1)
            begin
              state <= (!ovp_s && src_ok_s) ? ST_DET_BEGIN : ST_RETRY;
              tmr <= 32'h0;
            end
          end
          ST_RETRY:
          begin
            // Retest the weak source after the interval
            if (tmr >= RETRY_CYC - 1)
            begin
              state <= ST_QUALIFY;
              tmr <= 32'h0;
            end
          end
          ST_DET_BEGIN:
          begin
            tmr <= 32'h0;
            // Contact detection waits for power good
            if (det_done)
              state <= go_hiz ? ST_HIZ_HOLD : ST_READY;
            else if (pg_status)
              state <= ST_DCD_SRC;
          end
          ST_DCD_SRC:
          begin
            // Source and pull-down on for the fixed window
            if (tmr >= DCD_SRC_CYC - 1)
            begin
              state <= ST_DCD_WAIT;
              tmr <= 32'h0;
            end
          end
          ST_DCD_WAIT:
          begin
            // D+ falling low ends the wait early
            if (det_done)
              state <= go_hiz ? ST_HIZ_HOLD : ST_READY;
            else if (!dp_s)
            begin
              state <= ST_PRIMARY;
              tmr <= 32'h0;
            end
          end
          ST_PRIMARY:
          begin
            if (det_done)
              state <= go_hiz ? ST_HIZ_HOLD : ST_READY;
          end
          ST_READY:
          begin
            // Forced detection from the ready state
            if (hiz_bit)
              state <= ST_HIZ_HOLD;
            else if (force_det)
              state <= ST_DET_BEGIN;
          end
          ST_HIZ_HOLD:
          begin
            // Leaves once the bit is cleared, or to idle when the input is removed
            if (!hiz_bit)
            begin
              state <= ST_BIAS_DELAY;
              tmr <= 32'h0;
            end
          end
        endcase
        // A failed bias condition falls back to the bias delay state
        if (state != ST_IDLE && state != ST_BIAS_DELAY && state != ST_HIZ_HOLD && !bias_cond)
        begin
          state <= ST_BIAS_DELAY;
          tmr <= 32'h0;
        end
      end
    end
  end

  // Input control register: high-impedance bit and limit field
  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
    begin
      hiz_bit <= 1'b0;
      limit_field <= LIMIT_RST;
    end
    else if (ce_i)
    begin
      // Host value is stored and used directly
      if (wr_input)
      begin
        hiz_bit <= reg_wdata_i[HIZ_BIT];
        limit_field <= reg_wdata_i[2:0];
      end
      // Default mode drops the bit once the input leaves
      if (!vbus_s && !host_mode)
        hiz_bit <= 1'b0;
      // Detection result overrides an earlier write
      if (det_done)
        limit_field <= det_lim;
      // Hardware set wins over a same-cycle clear
      if (go_hiz)
        hiz_bit <= 1'b1;
    end
  end

  // System control register: force, disable, watchdog
  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
    begin
      force_det <= 1'b0;
      bsw_dis <= 1'b0;
      ship_mode <= 1'b0;
      wdog_field <= WDOG_RST;
    end
    else if (ce_i)
    begin
      // Completion clears the bit; a fresh write keeps it
      if (det_done)
        force_det <= 1'b0;
      if (wr_sys)
      begin
        force_det <= reg_wdata_i[FORCE_DET_BIT];
        bsw_dis <= reg_wdata_i[BSW_DIS_BIT];
        wdog_field <= reg_wdata_i[WDOG_LSB +: 2];
        // Both fields in one write arm shipping mode
        ship_mode <= reg_wdata_i[BSW_DIS_BIT] && reg_wdata_i[WDOG_LSB +: 2] == WDOG_OFF;
      end
      else if (vbus_attach && ship_mode)
      begin
        // An adapter attach releases shipping mode
        bsw_dis <= 1'b0;
        ship_mode <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
      host_mode <= HOST_MODE_RST;
    else if (ce_i && reg_wr_i && reg_addr_i == ADDR_MODE)
      host_mode <= reg_wdata_i[HOST_MODE_BIT];
  end

  // Power good status, source type and interrupt pulse
  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
    begin
      pg_status <= 1'b0;
      src_type <= SRC_NONE;
      int_o <= 1'b0;
    end
    else if (ce_i)
    begin
      int_o <= 1'b0;
      if (!vbus_s)
      begin
        pg_status <= 1'b0;
        src_type <= SRC_NONE;
      end
      // Passing qualification reports power good once
      else if (state == ST_QUALIFY && tmr >= QUAL_SETTLE_CYC - 1 && !ovp_s && src_ok_s && !pg_status)
      begin
        pg_status <= 1'b1;
        int_o <= 1'b1;
      end
      if (det_done)
        src_type <= det_type;
    end
  end

  // Overload on battery latches the switch open until attach
  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
      ovl_latch <= 1'b0;
    else if (ce_i)
    begin
      if (vbus_attach)
        ovl_latch <= 1'b0;
      else if (!vbus_s && ovl_s)
        ovl_latch <= 1'b1;
    end
  end

  // Registered pin drives; the switch opens the cycle the latch sets
  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
    begin
      bias_regulator_en_o <= 1'b0;
      test_load_en_o <= 1'b0;
      dp_current_src_en_o <= 1'b0;
      dm_pulldown_en_o <= 1'b0;
      dp_voltage_src_en_o <= 1'b0;
      dm_current_sink_en_o <= 1'b0;
      input_limit_o <= LIM_100MA;
    end
    else if (ce_i)
    begin
      bias_regulator_en_o <= vbus_s && state != ST_IDLE && state != ST_BIAS_DELAY && state != ST_HIZ_HOLD;
      test_load_en_o <= state == ST_QUALIFY;
      dp_current_src_en_o <= state == ST_DCD_SRC || state == ST_DCD_WAIT;
      dm_pulldown_en_o <= state == ST_DCD_SRC || state == ST_DCD_WAIT;
      dp_voltage_src_en_o <= state == ST_PRIMARY;
      dm_current_sink_en_o <= state == ST_PRIMARY;
      // Soft-start clamp, then the lower of field and pin
      if (!sys_ok_s)
        input_limit_o <= LIM_100MA;
      else
        input_limit_o <= (ext_lim_s < limit_field) ? ext_lim_s : limit_field;
    end
  end

  // Battery feeds the system above depletion; disable overrides
  assign battery_switch_on_o = !bsw_dis && !ovl_latch && (vbus_s || depl_s);
  // Open-drain power good pin, pulled low while power is good
  assign power_good_pin_o = 1'b0;
  assign power_good_pin_oe_n_o = ~pg_status;

  // Register read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (soft_rst)
      reg_rdata_o <= 8'h00;
    else if (ce_i)
    begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i)
      begin
        unique case (reg_addr_i)
          ADDR_INPUT_CTRL: reg_rdata_o <= {hiz_bit, 4'h0, limit_field};
          ADDR_SYS_CTRL: reg_rdata_o <= {force_det, 1'b0, bsw_dis, 3'h0, wdog_field};
          ADDR_STATUS: reg_rdata_o <= {src_type, 3'h0, pg_status, state == ST_HIZ_HOLD, battery_switch_on_o};
          ADDR_MODE: reg_rdata_o <= {7'h00, host_mode};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  a_bsw_forced_off: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    bsw_dis |-> !battery_switch_on_o) else $error("battery switch closed while disabled");
  a_overload_opens: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    (ce_i && !vbus_s && ovl_s && !vbus_attach) |=> !battery_switch_on_o) else $error("switch stayed on after overload");
  a_bias_needs_input: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    $rose(bias_regulator_en_o) |-> $past(vbus_s) && $past(state) != ST_BIAS_DELAY) else $error("bias on without input");
  a_hiz_bias_off: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    (ce_i && state == ST_HIZ_HOLD) |=> !bias_regulator_en_o) else $error("bias on in high impedance");
  a_pg_with_int: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    $rose(pg_status) |-> int_o && !power_good_pin_oe_n_o) else $error("power good without interrupt");
  a_dcd_needs_pg: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    $rose(dp_current_src_en_o) |-> pg_status) else $error("contact detect before power good");
  a_force_clears: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    (ce_i && det_done && !wr_sys) |=> !force_det) else $error("force bit stuck after detection");
  a_soft_start: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    (ce_i && !sys_ok_s) |=> input_limit_o == LIM_100MA) else $error("limit not clamped in soft-start");
  a_host_hiz_hold: assert property (@(posedge core_clk_i) disable iff (soft_rst)
    (ce_i && vbus_s && state == ST_HIZ_HOLD && host_mode && hiz_bit && !wr_input) |=> state == ST_HIZ_HOLD)
    else $error("left high impedance in host mode");
endmodule
